// File: rtl/rrc_fsk_pulse_shaper.sv
// root-raised-cosine shaper: byte serialiser, 72-tap fir and dac code
//
// Behaviour
// (R1) Frame bytes are consumed msb first, starting with the first preamble byte.
// (R2) Bits leave as one unbroken nrz stream, each held a full bit period with no gaps.
// (R3) The bit rate is 4800 bit/s within three percent.
// (R4) The nrz stream is shaped by a root-raised-cosine filter, T of 1/4800 s, roll-off 0.96.
// (R5) The filter is a 71st-order fir with 72 taps over a delay line of input samples.
// (R6) One output sample is made per 43.2 kHz tick, nine per bit.
// (R7) Products add in a 32-bit accumulator rounded to 16 bits once per sample.
// (R8) Tap weights are the fixed symmetric q15 table in order, centre 4595, ends -18; the code's tap 71 is -9.
// (R9) Each output sample is delivered as a 12-bit converter code.
// (R10) Any shaping structure is fine if its responses match the specified filter.
// (R11) A digital fir realisation is recommended but optional.
// (R12) The source opens each frame with the 48-bit correlation pattern, sync word, payload.
// (R13) No start, stop or separator bits sit between bytes or blocks.
// (R14) A bit maps to plus or minus full scale, held nine ticks before the next is asked for.
// (R15) The 16-bit result keeps its upper twelve bits, offset binary if asked.
`timescale 1ns/1ps

module rrc_fsk_pulse_shaper
  import shaper_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV  = SAMPLE_CYCLES,
  parameter bit          DAC_OFFSET  = 1'b1
)(
  // clock and reset
  input  wire logic                clock,
  input  wire logic                sys_rst,
  // byte stream from the frame encoder
  input  wire shaper_pkg::byte_in_t byte_in,
  output      logic                byte_ready,
  // status
  output      logic                underrun,
  // converter side
  output      shaper_pkg::dac_out_t dac_out,
  output      logic signed [15:0]  sample_out
);
  import shaper_pkg::*;

  // ---------------------------------------------------------------
  // coefficient table
  // ---------------------------------------------------------------
  function automatic logic signed [COEF_W-1:0] coef(input int unsigned i);
    logic signed [COEF_W-1:0] t [0:35];
    int unsigned k;
    t = '{-16'sd18, -16'sd9, 16'sd5, 16'sd18, 16'sd23, 16'sd17, 16'sd1, -16'sd17,
          -16'sd31, -16'sd33, -16'sd19, 16'sd5, 16'sd31, 16'sd45, 16'sd38, 16'sd11,
          -16'sd30, -16'sd65, -16'sd77, -16'sd54, 16'sd1, 16'sd70, 16'sd122, 16'sd124,
          16'sd55, -16'sd76, -16'sd228, -16'sd332, -16'sd302, -16'sd62, 16'sd431,
          16'sd1163, 16'sd2062, 16'sd3001, 16'sd3827, 16'sd4394};
    k = 0;
    // the set mirrors about tap 36 (4595); taps 37..71 reuse 35..1 and tap 0 stands alone
    if (i == 36)
      coef = 16'sd4595;
    else if (i < 36)
      coef = t[i];
    else
    begin
      k = 72 - i;
      coef = t[k];
    end
  endfunction // R8

  // ---------------------------------------------------------------
  // sample tick
  // ---------------------------------------------------------------
  logic [15:0] div_r;
  logic        tick;

  assign tick = (div_r == 16'((SAMPLE_DIV - 1)));

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      div_r <= 16'h0000;
    else if (tick)
      div_r <= 16'h0000;
    else
      div_r <= div_r + 16'h0001; // R3 R6
  end

  // ---------------------------------------------------------------
  // serialiser: msb first, nine ticks per bit, no gaps
  // ---------------------------------------------------------------
  logic [7:0] shift_r;
  logic [2:0] bitcnt_r;
  logic [3:0] phase_r;
  logic       have_r;
  logic       bit_end;
  logic       need_byte;

  assign bit_end   = tick && (phase_r == 4'(SAMPLES_PER_BIT - 1));
  assign need_byte = !have_r || (bit_end && bitcnt_r == 3'h7);
  // ready only at the moment a fresh byte is needed, so the next byte follows directly
  assign byte_ready = need_byte; // R13

  // held at zero while idle so the first bit of a frame gets all nine ticks
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      phase_r <= 4'h0;
    else if (!have_r)
      phase_r <= 4'h0; // R2 R14
    else if (tick)
      phase_r <= bit_end ? 4'h0 : phase_r + 4'h1; // R14
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_r  <= 8'h00;
      bitcnt_r <= 3'h0;
      have_r   <= 1'b0;
    end
    else if (need_byte)
    begin
      have_r   <= byte_in.valid;
      shift_r  <= byte_in.data; // R1
      bitcnt_r <= 3'h0;
    end
    else if (bit_end)
    begin
      shift_r  <= {shift_r[6:0], 1'b0}; // R1 R2
      bitcnt_r <= bitcnt_r + 3'h1;
    end
  end

  // a stall mid-frame would break the nrz stream; flag it for the framer
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      underrun <= 1'b0;
    else
      underrun <= have_r && need_byte && !byte_in.valid; // R2
  end

  // ---------------------------------------------------------------
  // delay line and serial mac, one tap per clock
  // ---------------------------------------------------------------
  logic signed [15:0]      level;
  logic signed [15:0]      line_r [0:NUM_TAPS-1];
  logic signed [ACC_W-1:0] acc_r;
  logic [6:0]              tap_r;
  logic                    busy_r;
  logic signed [ACC_W-1:0] prod;
  logic signed [ACC_W-1:0] rnd;

  // idle (no byte) sends mid-scale so the filter rings down cleanly
  assign level = !have_r ? 16'sh0000 : (shift_r[7] ? LEVEL_ONE : LEVEL_ZERO); // R14
  assign prod  = ACC_W'(line_r[tap_r] * coef(int'(tap_r))); // R5 R8

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      for (int i = 0; i < NUM_TAPS; i++)
        line_r[i] <= 16'sh0000;
    else if (tick)
    begin
      line_r[0] <= level;
      for (int i = 1; i < NUM_TAPS; i++)
        line_r[i] <= line_r[i-1]; // R4 R5 R10 R11
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_r  <= ACC_RST;
      tap_r  <= 7'h00;
      busy_r <= 1'b0;
    end
    else if (tick)
    begin
      acc_r  <= ACC_RST;
      tap_r  <= 7'h00;
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      acc_r <= acc_r + prod; // R7
      tap_r <= tap_r + 7'h01;
      if (tap_r == 7'(NUM_TAPS - 1))
        busy_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // rounding and converter code
  // ---------------------------------------------------------------
  logic done_r;
  logic signed [15:0] q16;

  assign rnd = acc_r + (32'sh1 <<< (FRAC_BITS - 1));
  assign q16 = rnd[FRAC_BITS +: OUT_W]; // R7

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      done_r <= 1'b0;
    else
      done_r <= busy_r && (tap_r == 7'(NUM_TAPS - 1));
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sample_out     <= OUT_RST;
      dac_out.code   <= DAC_OFFSET ? DAC_RST : 12'h000;
      dac_out.strobe <= 1'b0;
    end
    else
    begin
      dac_out.strobe <= done_r; // R6 R9
      if (done_r)
      begin
        sample_out   <= q16;
        dac_out.code <= {q16[15] ^ DAC_OFFSET, q16[14:4]}; // R15
      end
    end
  end

endmodule

// File: rtl/shaper_pkg.sv
// constants and carrier types for the root-raised-cosine bit shaper
package shaper_pkg;

  // timing: 100 MHz system clock
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned BIT_RATE_BPS   = 4800;
  localparam int unsigned SAMPLE_RATE_HZ = 43_200;
  localparam int unsigned SAMPLES_PER_BIT = SAMPLE_RATE_HZ / BIT_RATE_BPS;
  // cycles between sample ticks, rounded down (error well inside 3 %)
  localparam int unsigned SAMPLE_CYCLES  = CLK_HZ / SAMPLE_RATE_HZ;

  // filter geometry
  localparam int unsigned NUM_TAPS  = 72;
  localparam int unsigned COEF_W    = 16;
  localparam int unsigned ACC_W     = 32;
  localparam int unsigned OUT_W     = 16;
  localparam int unsigned DAC_W     = 12;
  localparam int unsigned FRAC_BITS = 15;

  // full-scale input levels for a one and a zero
  localparam logic signed [15:0] LEVEL_ONE  = 16'sh7fff;
  localparam logic signed [15:0] LEVEL_ZERO = -16'sh7fff;

  // reset values
  localparam logic [ACC_W-1:0] ACC_RST  = 32'h0000_0000;
  localparam logic [DAC_W-1:0] DAC_RST  = 12'h800;
  localparam logic [OUT_W-1:0] OUT_RST  = 16'h0000;

  // upstream byte stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_in_t;

  // converter output
  typedef struct packed {
    logic             strobe;
    logic [DAC_W-1:0] code;
  } dac_out_t;

endpackage

// File: tb/encoder_model.sv
// frame encoder model: offers queued bytes back to back, drops valid when empty
`timescale 1ns/1ps
module encoder_model
  import shaper_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           sys_rst,
  input  wire logic           byte_ready,
  output shaper_pkg::byte_in_t byte_in
);
  logic [7:0] q[$];
  bit         armed;
  initial byte_in = 9'h000;
  // ready settles by the falling edge and equals what the next rising edge samples
  always @(negedge clock)
  begin
    if (sys_rst)
    begin
      q.delete();
      byte_in.valid = 1'b0;
    end
    else if (armed || !byte_in.valid)
      byte_in = (q.size() > 0) ? {1'b1, q.pop_front()} : {1'b0, ~byte_in.data};
    armed = byte_ready && byte_in.valid;
  end
endmodule

// File: tb/shaper_assertions.sv
// port checker for the rrc bit shaper, bound into every instance
`timescale 1ns/1ps
module shaper_checker
  import shaper_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV = SAMPLE_CYCLES
)(
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire shaper_pkg::byte_in_t byte_in,
  input wire logic                 byte_ready,
  input wire logic                 underrun,
  input wire shaper_pkg::dac_out_t dac_out,
  input wire logic signed [15:0]   sample_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [15:0] gap_r;
  logic        seen_r;
  // cycles since the last strobe; the first strobe after reset has no reference
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end
    else
    begin
      gap_r  <= dac_out.strobe ? 16'h0001 : gap_r + 16'h0001;
      seen_r <= seen_r | dac_out.strobe;
    end
  property p_tick_spacing;
    dac_out.strobe && seen_r |-> gap_r == 16'(SAMPLE_DIV);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("strobe spacing wrong");
  property p_strobe_pulse;
    dac_out.strobe |=> !dac_out.strobe [*8];
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_code_map;
    dac_out.strobe |-> dac_out.code == {~sample_out[15], sample_out[14:4]};
  endproperty
  a_code_map: assert property (p_code_map) else $error("dac code not top bits");
  property p_code_hold;
    !dac_out.strobe |-> $stable(dac_out.code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("dac code moved");
  property p_sample_hold;
    !dac_out.strobe |-> $stable(sample_out);
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sample moved");
  property p_take_drop;
    byte_ready && byte_in.valid |=> !byte_ready [*8];
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("ready after take");
  property p_underrun_cause;
    underrun |-> $past(byte_ready && !byte_in.valid);
  endproperty
  a_underrun_cause: assert property (p_underrun_cause) else $error("bad underrun");
  property p_underrun_idle;
    underrun |-> byte_ready ##1 !underrun;
  endproperty
  a_underrun_idle: assert property (p_underrun_idle) else $error("underrun not idle");
endmodule

bind rrc_fsk_pulse_shaper shaper_checker #(.SAMPLE_DIV(SAMPLE_DIV)) u_chk (.clock(clock),
  .sys_rst(sys_rst), .byte_in(byte_in), .byte_ready(byte_ready), .underrun(underrun),
  .dac_out(dac_out), .sample_out(sample_out));

// File: tb/tb.sv
// self-checking bench for the rrc bit shaper
`timescale 1ns/1ps
module tb;
  import shaper_pkg::*;
  localparam int DIV = 100;
  logic clock, sys_rst, byte_ready, underrun;
  shaper_pkg::byte_in_t byte_in;
  shaper_pkg::dac_out_t dac_out;
  logic signed [15:0] sample_out;
  int errors, total_checks, n_under;
  int h[37] = '{-18, -9, 5, 18, 23, 17, 1, -17, -31, -33, -19, 5, 31, 45, 38, 11, -30, -65,
    -77, -54, 1, 70, 122, 124, 55, -76, -228, -332, -302, -62, 431, 1163, 2062, 3001, 3827,
    4394, 4595};
  rrc_fsk_pulse_shaper #(.SAMPLE_DIV(DIV)) u_dut (.clock(clock), .sys_rst(sys_rst),
    .byte_in(byte_in), .byte_ready(byte_ready), .underrun(underrun), .dac_out(dac_out),
    .sample_out(sample_out));
  encoder_model u_enc (.clock(clock), .sys_rst(sys_rst), .byte_ready(byte_ready),
    .byte_in(byte_in));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge clock) if (underrun === 1'b1) n_under++;
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic next_strobe();
    int n;
    n = 0;
    @(negedge clock);
    while (dac_out.strobe !== 1'b1)
    begin
      @(negedge clock);
      if (++n > 2 * DIV)
      begin
        errors++;
        $display("MISMATCH t=%0t no strobe", $time);
        end_of_test();
      end
    end
  endtask
  // newest sample meets the first weight; wraps like the 16-bit result
  function automatic logic [15:0] ref_out(input logic [15:0] bits, input int m);
    logic signed [63:0] acc;
    acc = 64'sd16384;
    for (int k = 0; k < 72; k++)
      if (m - k >= 0 && m - k < 144)
        acc += (k <= 36 ? h[k] : h[72 - k]) * (bits[15 - (m - k) / 9] ? 32767 : -32767);
    return acc[30:15];
  endfunction
  task automatic reset_test();
    u_enc.q.push_back(8'hff);
    u_enc.q.push_back(8'h00);
    repeat (20) next_strobe();
    sys_rst = 1'b1;
    @(negedge clock);
    check16(sample_out, 16'h0000, "reset sample");
    check16({1'b0, dac_out, byte_ready, underrun}, {2'b00, 12'h800, 2'b10}, "reset pins");
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    $display("reset test done");
  endtask
  task automatic stream_test();
    logic [15:0] bits;
    logic [15:0] want;
    int m;
    bits = 16'hb433;
    n_under = 0;
    u_enc.q.push_back(bits[15:8]);
    u_enc.q.push_back(bits[7:0]);
    m = 0;
    while (sample_out === 16'h0000)
    begin
      if (++m > 200)
      begin
        errors++;
        $display("MISMATCH t=%0t stream never started", $time);
        end_of_test();
      end
      next_strobe();
    end
    for (m = 0; m < 220; m++)
    begin
      want = ref_out(bits, m);
      check16(sample_out, want, "filter output");
      check16({4'h0, dac_out.code}, {4'h0, ~want[15], want[14:4]}, "dac code");
      next_strobe();
    end
    check16(16'(n_under), 16'h0001, "underrun count");
    check16({15'h0000, byte_ready}, 16'h0001, "idle ready");
    $display("stream test done");
  endtask
  initial
  begin
    sys_rst = 1'b1;
    errors = 0;
    total_checks = 0;
    n_under = 0;
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    reset_test();
    stream_test();
    end_of_test();
  end
endmodule
